// >>> core/lcdd_consts.svh
// Purpose: constants for the dot-matrix lcd driver
// Assumes: 20 MHz core clock
// Notes: counts derive from times in ns
`ifndef LCDD_CONSTS_SVH
`define LCDD_CONSTS_SVH
`define LCDD_CLK_NS 50
`define LCDD_SLOT_NS 32000
`define LCDD_SLOT_CYC ((`LCDD_SLOT_NS + `LCDD_CLK_NS - 1) / `LCDD_CLK_NS)
`define LCDD_SLOT_W 10
`define LCDD_MEM_BYTES 402
`define LCDD_PAGES 3'h6
`define LCDD_PAGE_BYTES 9'h043
`define LCDD_HI_FIRST 8'hF8
`define LCDD_HI_LAST 8'hFD
`define LCDD_LO_LAST 8'h42
`define LCDD_GAP_LO 8'h29
`define LCDD_GAP_HI 8'h32
`define LCDD_CTRL_ADDR 16'hFF10
`define LCDD_CTRL_DUTY 0
`define LCDD_CTRL_AREA 1
`define LCDD_CTRL_FONT 2
`define LCDD_STAT_DUTY_LSB 3
`define LCDD_STAT_AREA 6
`define LCDD_STAT_FONT 7
`define LCDD_SEGS 67
`define LCDD_COMS 32
`define LCDD_SHARED_LO 51
`define LCDD_SMALL_SEGS 41
`define LCDD_NCOM_32 6'h20
`define LCDD_NCOM_16 6'h10
`define LCDD_NCOM_8 6'h08
`define LCDD_F58_ROWS 5'h08
`define LCDD_F55_ROWS 5'h05
`define LCDD_AREA1_PAGE 3'h3
`endif

// >>> core/lcdd_pkg.sv
// Purpose: types shared by the lcd driver modules
// Assumes: lcdd_consts.svh on the include path
// Notes: duty codes are one-hot
`default_nettype none
`include "lcdd_consts.svh"
package lcdd_pkg;
  typedef enum logic [2:0] {
    LCDD_DUTY_32 = 3'b001,
    LCDD_DUTY_16 = 3'b010,
    LCDD_DUTY_8 = 3'b100
  } lcdd_duty_type;
  typedef struct packed {
    logic hit;
    logic valid;
    logic [8:0] idx;
  } lcdd_dec_type;
  typedef struct packed {
    logic valid;
    logic [8:0] base;
    logic [2:0] bitpos;
  } lcdd_map_type;
  typedef struct packed {
    logic [`LCDD_SLOT_W-1:0] cnt;
    logic [4:0] com;
  } lcdd_tim_type;
  typedef struct packed {
    logic [`LCDD_MEM_BYTES-1:0][7:0] mem;
    logic duty_sel;
    logic area_sel;
    logic font_sel;
    lcdd_duty_type duty;
    logic area;
    logic font;
    logic load;
    logic [7:0] rdata;
    logic [`LCDD_COMS-1:0] coms;
    logic [`LCDD_SEGS-1:0] segs;
  } lcdd_state_type;
endpackage : lcdd_pkg
`default_nettype wire

// >>> core/lcdd_scan_timer.sv
// Purpose: slot and common sequencer for the lcd scan
// Assumes: ncom_in changes only at a frame boundary
// Notes: com_out is the common of the slot now running
`default_nettype none
`include "lcdd_consts.svh"
module lcdd_scan_timer (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic [5:0] ncom_in,
  output logic tick_out,
  output logic frame_out,
  output logic [4:0] com_out
);
  lcdd_pkg::lcdd_tim_type st;
  lcdd_pkg::lcdd_tim_type next_st;
  logic last_com;

  assign tick_out = (st.cnt == `LCDD_SLOT_W'(`LCDD_SLOT_CYC - 1));
  assign last_com = ({1'b0, st.com} == (ncom_in - 6'h01));
  assign frame_out = tick_out && last_com;
  assign com_out = st.com;

  always_comb begin
    next_st = st;
    next_st.cnt = st.cnt + `LCDD_SLOT_W'(1);
    if (tick_out) begin
      next_st.cnt = '0;
      // one common per slot, wrapping at the frame length
      next_st.com = last_com ? 5'h00 : st.com + 5'h01;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);

  property p_slot_gap;
    tick_out |=> !tick_out;
  endproperty
  a_slot_gap: assert property (p_slot_gap) else $error("slot shorter than two cycles");

  property p_com_range;
    ({1'b0, com_out} < ncom_in);
  endproperty
  a_com_range: assert property (p_com_range) else $error("common index past frame");
endmodule : lcdd_scan_timer
`default_nettype wire

// >>> core/lcdd_driver.sv
// Purpose: dot-matrix lcd driver with display memory and scan
// Assumes: cpu port strobes one cycle, never both at once
// Notes: SMALL_VARIANT and FIXED_DUTY_8 are build options
// Contract
// - build option picks switchable 1/32-1/16 duty or fixed 1/8 duty
// - switchable: duty bit clear gives 1/32, set gives 1/16
// - fixed option: always 1/8, duty bit write has no effect
// - 1/32: shared pins are commons, com 0-31 and seg 0-50 driven
// - 1/16: shared pins are segments, com 0-15 and seg 0-66 driven
// - 1/8: 67 segments by 8 commons, com 8-15 held off
// - small variant: 342 bytes, 41 segments at 1/32, 57 otherwise
// - large variant: 402 bytes decoded in F800H-FD42H with gaps
// - bit-to-dot map depends on duty and font layout
// - at 1/16 and 1/8, screen bit picks area 0 or area 1
// - font bit clear gives 5x8 layout, set gives 5x5 layout
// - memory bit one lights its dot, zero leaves it dark
// - display memory fully readable and writable by the cpu
// - unmapped memory bits still work as plain storage
// - display memory range always served internally
//
// Decided for this implementation: the address map and the strobed register port.
`default_nettype none
`include "lcdd_consts.svh"
module lcdd_driver #(
  parameter bit SMALL_VARIANT = 1'b0,
  parameter bit FIXED_DUTY_8 = 1'b0
) (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic [15:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  output logic mem_hit_out,
  output logic [`LCDD_COMS-1:0] common_outputs_out,
  output logic [`LCDD_SEGS-1:0] segment_outputs_out
);
  lcdd_pkg::lcdd_state_type st;
  lcdd_pkg::lcdd_state_type next_st;
  lcdd_pkg::lcdd_dec_type dec;
  lcdd_pkg::lcdd_map_type map;
  lcdd_pkg::lcdd_duty_type cfg_duty;
  logic tick;
  logic frame;
  logic [4:0] com;
  logic [5:0] ncom;

  // address decode, shared by the cpu port and the hit output
  function automatic lcdd_pkg::lcdd_dec_type decode(input logic [15:0] a);
    lcdd_pkg::lcdd_dec_type d;
    logic [2:0] page;
    page = 3'(a[15:8] - `LCDD_HI_FIRST);
    d.hit = (a[15:8] >= `LCDD_HI_FIRST) && (a[15:8] <= `LCDD_HI_LAST)
      && !((a[15:8] == `LCDD_HI_LAST) && (a[7:0] > `LCDD_LO_LAST));
    d.valid = d.hit && (a[7:0] <= `LCDD_LO_LAST)
      && !(SMALL_VARIANT && (a[7:0] >= `LCDD_GAP_LO)
      && (a[7:0] <= `LCDD_GAP_HI));
    d.idx = 9'(page) * `LCDD_PAGE_BYTES + 9'(a[6:0]);
    return d;
  endfunction : decode

  function automatic logic [5:0] frame_len(input lcdd_pkg::lcdd_duty_type d);
    case (d)
      lcdd_pkg::LCDD_DUTY_32: frame_len = `LCDD_NCOM_32;
      lcdd_pkg::LCDD_DUTY_16: frame_len = `LCDD_NCOM_16;
      lcdd_pkg::LCDD_DUTY_8: frame_len = `LCDD_NCOM_8;
      default: frame_len = `LCDD_NCOM_32;
    endcase
  endfunction : frame_len

  // common to memory page and bit; 5x5 packs five rows per byte
  function automatic lcdd_pkg::lcdd_map_type map_com(
    input lcdd_pkg::lcdd_duty_type d,
    input logic f,
    input logic ar,
    input logic [4:0] c
  );
    lcdd_pkg::lcdd_map_type m;
    logic [4:0] rows;
    logic [2:0] page;
    rows = f ? `LCDD_F55_ROWS : `LCDD_F58_ROWS;
    page = 3'(c / rows);
    m.bitpos = 3'(c % rows);
    if ((d != lcdd_pkg::LCDD_DUTY_32) && ar) begin
      page = page + `LCDD_AREA1_PAGE;
    end
    m.valid = (page < `LCDD_PAGES) && ({1'b0, c} < frame_len(d));
    m.base = 9'(page) * `LCDD_PAGE_BYTES;
    return m;
  endfunction : map_com

  function automatic logic seg_live(
    input lcdd_pkg::lcdd_duty_type d,
    input int s
  );
    logic wide;
    wide = (d != lcdd_pkg::LCDD_DUTY_32);
    if (s >= `LCDD_SHARED_LO) begin
      seg_live = wide;
    end else if (SMALL_VARIANT) begin
      seg_live = (s < `LCDD_SMALL_SEGS);
    end else begin
      seg_live = 1'b1;
    end
  endfunction : seg_live

  lcdd_scan_timer u_timer (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .ncom_in(ncom),
    .tick_out(tick),
    .frame_out(frame),
    .com_out(com)
  );

  assign ncom = frame_len(st.duty);
  assign dec = decode(addr_in);
  // also asserted for gap addresses so the external bus stays off
  assign mem_hit_out = dec.hit && (wr_in || rd_in);
  assign map = map_com(st.duty, st.font, st.area, com);
  assign rdata_out = st.rdata;
  assign common_outputs_out = st.coms;
  assign segment_outputs_out = st.segs;

  always_comb begin
    cfg_duty = lcdd_pkg::LCDD_DUTY_32;
    if (FIXED_DUTY_8) begin
      cfg_duty = lcdd_pkg::LCDD_DUTY_8;
    end else if (st.duty_sel) begin
      cfg_duty = lcdd_pkg::LCDD_DUTY_16;
    end
  end

  always_comb begin
    next_st = st;
    next_st.load = tick;
    next_st.rdata = 8'h00;
    // plain storage whatever the display map uses
    if (wr_in && dec.valid) begin
      next_st.mem[dec.idx] = wdata_in;
    end
    if (wr_in && (addr_in == `LCDD_CTRL_ADDR)) begin
      next_st.duty_sel = wdata_in[`LCDD_CTRL_DUTY];
      next_st.area_sel = wdata_in[`LCDD_CTRL_AREA];
      next_st.font_sel = wdata_in[`LCDD_CTRL_FONT];
    end
    if (rd_in && dec.valid) begin
      next_st.rdata = st.mem[dec.idx];
    end else if (rd_in && (addr_in == `LCDD_CTRL_ADDR)) begin
      next_st.rdata[`LCDD_CTRL_DUTY] = st.duty_sel;
      next_st.rdata[`LCDD_CTRL_AREA] = st.area_sel;
      next_st.rdata[`LCDD_CTRL_FONT] = st.font_sel;
      next_st.rdata[`LCDD_STAT_DUTY_LSB+:3] = st.duty;
      next_st.rdata[`LCDD_STAT_AREA] = st.area;
      next_st.rdata[`LCDD_STAT_FONT] = st.font;
    end
    // selections wait for the wrap so no frame mixes settings
    if (frame) begin
      next_st.duty = cfg_duty;
      next_st.area = st.area_sel;
      next_st.font = st.font_sel;
    end
    // load one cycle after the tick so the new common index and settings are seen
    if (st.load) begin
      next_st.coms = '0;
      next_st.segs = '0;
      if (map.valid) begin
        next_st.coms[com] = 1'b1;
        for (int s = 0; s < `LCDD_SEGS; s++) begin
          if (seg_live(st.duty, s)) begin
            next_st.segs[s] = st.mem[map.base + 9'(s)][map.bitpos];
          end
        end
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      st <= '0;
      // load at release so the first slot shows common 0 instead of staying dark
      st.load <= 1'b1;
      st.duty <= FIXED_DUTY_8 ? lcdd_pkg::LCDD_DUTY_8 : lcdd_pkg::LCDD_DUTY_32;
    end else begin
      st <= next_st;
    end
  end

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);

  property p_fixed;
    FIXED_DUTY_8 |-> (st.duty == lcdd_pkg::LCDD_DUTY_8);
  endproperty
  a_fixed: assert property (p_fixed) else $error("fixed option left 1/8 duty");

  property p_duty_pick;
    (frame && !FIXED_DUTY_8) |=>
      (st.duty == ($past(st.duty_sel) ? lcdd_pkg::LCDD_DUTY_16 : lcdd_pkg::LCDD_DUTY_32));
  endproperty
  a_duty_pick: assert property (p_duty_pick) else $error("duty bit not honoured");

  property p_cfg_hold;
    !frame |=> ($stable(st.duty) && $stable(st.area) && $stable(st.font));
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("setting changed mid frame");

  property p_com_onehot;
    $onehot0(common_outputs_out);
  endproperty
  a_com_onehot: assert property (p_com_onehot) else $error("two commons active");

  property p_com8_off;
    (st.duty == lcdd_pkg::LCDD_DUTY_8) && $stable(st.duty)
      |-> (common_outputs_out[15:8] == 8'h00);
  endproperty
  a_com8_off: assert property (p_com8_off) else $error("common 8-15 driven at 1/8");

  property p_shared_com;
    (st.duty == lcdd_pkg::LCDD_DUTY_32) && $stable(st.duty)
      |-> (segment_outputs_out[66:51] == 16'h0000);
  endproperty
  a_shared_com: assert property (p_shared_com) else $error("shared pins as segments");

  property p_shared_seg;
    (st.duty != lcdd_pkg::LCDD_DUTY_32) && $stable(st.duty)
      |-> (common_outputs_out[31:16] == 16'h0000);
  endproperty
  a_shared_seg: assert property (p_shared_seg) else $error("shared pins as commons");

  property p_small_segs;
    SMALL_VARIANT |-> (segment_outputs_out[50:41] == 10'h000);
  endproperty
  a_small_segs: assert property (p_small_segs) else $error("small variant extra segment");

  sequence s_mem_write;
    wr_in && dec.valid;
  endsequence
  sequence s_same_read;
    rd_in && (addr_in == $past(addr_in));
  endsequence
  property p_readback;
    s_mem_write ##1 s_same_read |=> (rdata_out == $past(wdata_in, 2));
  endproperty
  a_readback: assert property (p_readback) else $error("display memory readback wrong");

  property p_rd_idle;
    !rd_in |=> (rdata_out == 8'h00);
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");

  property p_hit_range;
    ((wr_in || rd_in) && (addr_in >= {`LCDD_HI_FIRST, 8'h00})
      && (addr_in <= {`LCDD_HI_LAST, `LCDD_LO_LAST})) |-> mem_hit_out;
  endproperty
  a_hit_range: assert property (p_hit_range) else $error("display range not claimed");

  property p_hit_idle;
    !(wr_in || rd_in) |-> !mem_hit_out;
  endproperty
  a_hit_idle: assert property (p_hit_idle) else $error("idle hit");

  property p_outside_read;
    (rd_in && (addr_in != `LCDD_CTRL_ADDR) && ((addr_in < {`LCDD_HI_FIRST, 8'h00})
      || (addr_in > {`LCDD_HI_LAST, `LCDD_LO_LAST}))) |=> (rdata_out == 8'h00);
  endproperty
  a_outside_read: assert property (p_outside_read) else $error("stray read data");

  property p_small_gap;
    (SMALL_VARIANT && rd_in && (addr_in[7:0] >= `LCDD_GAP_LO)
      && (addr_in[7:0] <= `LCDD_GAP_HI)) |=> (rdata_out == 8'h00);
  endproperty
  a_small_gap: assert property (p_small_gap) else $error("gap holds data");

  sequence s_ctrl_write;
    wr_in && (addr_in == `LCDD_CTRL_ADDR);
  endsequence
  sequence s_ctrl_read;
    rd_in && (addr_in == `LCDD_CTRL_ADDR);
  endsequence
  property p_ctrl_readback;
    s_ctrl_write ##1 s_ctrl_read |=> (rdata_out[`LCDD_CTRL_FONT:`LCDD_CTRL_DUTY]
      == $past(wdata_in[`LCDD_CTRL_FONT:`LCDD_CTRL_DUTY], 2));
  endproperty
  a_ctrl_readback: assert property (p_ctrl_readback) else $error("select bits lost");

  sequence s_wrap;
    frame;
  endsequence
  sequence s_first_slot;
    st.load ##1 (common_outputs_out[`LCDD_COMS-1:1] == '0);
  endsequence
  property p_frame_restart;
    s_wrap |=> s_first_slot;
  endproperty
  a_frame_restart: assert property (p_frame_restart) else $error("no restart at 0");

  property p_com_order;
    $rose(common_outputs_out[2]) |-> $past(common_outputs_out[1]);
  endproperty
  a_com_order: assert property (p_com_order) else $error("commons out of order");

  property p_dark_no_com;
    (common_outputs_out == '0) |-> (segment_outputs_out == '0);
  endproperty
  a_dark_no_com: assert property (p_dark_no_com) else $error("dark slot lit");
endmodule : lcdd_driver
`default_nettype wire

// >>> verif/lcdd_panel.sv
// Purpose: behavioural lcd panel as seen from the common and segment electrodes
// Assumes: at most one common selected at a time
// Notes: two commons at once read as no select, so a bench wait then times out
`default_nettype none
`include "lcdd_consts.svh"
module lcdd_panel (
  input wire logic [`LCDD_COMS-1:0] common_in,
  input wire logic [`LCDD_SEGS-1:0] segment_in,
  output logic active_out,
  output logic [4:0] com_out,
  output logic [`LCDD_SEGS-1:0] lit_out
);
  timeunit 1ns;
  timeprecision 1ns;
  always_comb begin
    active_out = 1'b0;
    com_out = 5'h00;
    for (int i = 0; i < `LCDD_COMS; i++) begin
      if (common_in[i]) begin
        active_out = $onehot(common_in);
        com_out = 5'(i);
      end
    end
    lit_out = active_out ? segment_in : '0;
  end
endmodule : lcdd_panel
`default_nettype wire

// >>> verif/lcd_dot_matrix_driver_bench.sv
// Purpose: self-checking bench for the lcd driver
// Assumes: 20 MHz clock, both duty build options fed the same cpu traffic
// Notes: dut2 is the fixed 1/8 build and dut3 the small build, both fed the same traffic
`default_nettype none
`include "lcdd_consts.svh"
module lcd_dot_matrix_driver_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rd_q = 1'b0;
  logic [7:0] rdata;
  logic [7:0] rdata2;
  logic [7:0] rdata3;
  logic hit;
  logic hit2;
  logic act;
  logic [4:0] com;
  logic [`LCDD_COMS-1:0] coms;
  logic [`LCDD_COMS-1:0] coms2;
  logic [`LCDD_SEGS-1:0] segs;
  logic [`LCDD_SEGS-1:0] segs2;
  logic [`LCDD_SEGS-1:0] segs3;
  logic [`LCDD_SEGS-1:0] lit;
  logic [31:0] seed = 32'h00000B86;
  logic [15:0] tbl [4] = '{16'hF800, 16'hF842, 16'hFD00, 16'hFD42};
  logic [7:0] q [$];
  logic [7:0] q2 [$];
  logic [7:0] q3 [$];
  int bad_count = 0;
  int samples_checked = 0;
  lcdd_driver dut (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .addr_in(addr),
    .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .mem_hit_out(hit),
    .common_outputs_out(coms), .segment_outputs_out(segs));
  lcdd_driver #(.FIXED_DUTY_8(1'b1)) dut2 (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
    .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata2),
    .mem_hit_out(hit2), .common_outputs_out(coms2), .segment_outputs_out(segs2));
  lcdd_driver #(.SMALL_VARIANT(1'b1)) dut3 (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
    .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata3),
    .mem_hit_out(), .common_outputs_out(), .segment_outputs_out(segs3));
  lcdd_panel panel (.common_in(coms), .segment_in(segs), .active_out(act), .com_out(com),
    .lit_out(lit));
  initial begin
    forever #25 core_clk_in = ~core_clk_in;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic conclude();
    if (bad_count == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : conclude
  task automatic chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_byte
  task automatic chk_bit(input string nm, input logic e, input logic g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_bit
  // strobes stay up across back-to-back calls; idle() drops them
  task automatic op(input logic w, input logic [15:0] a, input logic [7:0] d,
    input logic [7:0] e, input logic [7:0] e2, input logic h);
    @(posedge core_clk_in);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    if (!w) begin
      q.push_back(e);
      q2.push_back(e2);
      q3.push_back(((a[7:0] >= `LCDD_GAP_LO) && (a[7:0] <= `LCDD_GAP_HI)) ? 8'h00 : e);
    end
    #1;
    chk_bit("mem_hit", h, hit);
  endtask : op
  task automatic idle();
    @(posedge core_clk_in);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : idle
  // waits for the panel to enter common c, never one already showing
  task automatic wait_com(input logic [4:0] c);
    int n;
    n = 0;
    @(negedge core_clk_in);
    while (act === 1'b1 && com === c && n < 25000) begin
      @(negedge core_clk_in);
      n++;
    end
    while (!(act === 1'b1 && com === c) && n < 25000) begin
      @(negedge core_clk_in);
      n++;
    end
    if (n >= 25000) begin
      bad_count++;
      conclude();
    end
  endtask : wait_com
  always @(posedge core_clk_in) begin
    if (rd_q) begin
      chk_byte("rdata", q.pop_front(), rdata);
      chk_byte("rdata_fixed", q2.pop_front(), rdata2);
      chk_byte("rdata_small", q3.pop_front(), rdata3);
    end
    rd_q <= rd;
  end
  initial begin
    repeat (4) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    op(1'b0, 16'hFF10, 8'h00, 8'h08, 8'h20, 1'b0);
    foreach (tbl[i]) begin
      seed = lfsr(seed);
      op(1'b1, tbl[i], seed[7:0], 8'h00, 8'h00, 1'b1);
      op(1'b0, tbl[i], 8'h00, seed[7:0], seed[7:0], 1'b1);
    end
    seed = lfsr(seed);
    op(1'b1, 16'hF830, seed[7:0], 8'h00, 8'h00, 1'b1);
    op(1'b0, 16'hF830, 8'h00, seed[7:0], seed[7:0], 1'b1);
    op(1'b1, 16'hFC43, 8'hFF, 8'h00, 8'h00, 1'b1);
    op(1'b0, 16'hFC43, 8'h00, 8'h00, 8'h00, 1'b1);
    op(1'b0, 16'hFD43, 8'h00, 8'h00, 8'h00, 1'b0);
    op(1'b0, 16'hF7FF, 8'h00, 8'h00, 8'h00, 1'b0);
    op(1'b1, 16'hF803, 8'h02, 8'h00, 8'h00, 1'b1);
    op(1'b1, 16'hF833, 8'h02, 8'h00, 8'h00, 1'b1);
    idle();
    wait_com(5'h01);
    chk_bit("seg3", 1'b1, lit[3]);
    chk_bit("seg4", 1'b0, lit[4]);
    chk_bit("seg51", 1'b0, lit[51]);
    chk_bit("fixed_com_hi", 1'b0, |coms2[31:8]);
    chk_bit("fixed_com1", 1'b1, coms2[1]);
    chk_bit("fixed_seg51", 1'b1, segs2[51]);
    op(1'b1, 16'hFF10, 8'h01, 8'h00, 8'h00, 1'b0);
    op(1'b0, 16'hFF10, 8'h00, 8'h09, 8'h21, 1'b0);
    idle();
    wait_com(5'h00);
    op(1'b0, 16'hFF10, 8'h00, 8'h11, 8'h21, 1'b0);
    op(1'b1, 16'hFF10, 8'h03, 8'h00, 8'h00, 1'b0);
    op(1'b1, 16'hFB07, 8'h02, 8'h00, 8'h00, 1'b1);
    op(1'b1, 16'hFB40, 8'h02, 8'h00, 8'h00, 1'b1);
    idle();
    wait_com(5'h00);
    wait_com(5'h01);
    chk_bit("area1_seg7", 1'b1, lit[7]);
    chk_bit("area0_seg3", 1'b0, lit[3]);
    chk_bit("seg64", 1'b1, lit[64]);
    chk_bit("com_hi", 1'b0, |coms[31:16]);
    chk_bit("fixed_com_hi2", 1'b0, |coms2[31:8]);
    chk_bit("small_seg64", 1'b1, segs3[64]);
    op(1'b1, 16'hFF10, 8'h07, 8'h00, 8'h00, 1'b0);
    op(1'b1, 16'hFC05, 8'h02, 8'h00, 8'h00, 1'b1);
    idle();
    wait_com(5'h00);
    wait_com(5'h06);
    chk_bit("font55_seg5", 1'b1, lit[5]);
    op(1'b0, 16'hFF10, 8'h00, 8'hD7, 8'hE7, 1'b0);
    idle();
    repeat (3) @(posedge core_clk_in);
    conclude();
  end
endmodule : lcd_dot_matrix_driver_bench
`default_nettype wire
